/* File: hdl/port_alt_defines.vh */
// Purpose: constants for the port 0 function-select block
// Assumes: AHB-Lite byte addresses, one register per aligned word
// Notes:   Printed offsets 18/20/28 are multiples of four, used as is
`ifndef PORT_ALT_DEFINES_VH
`define PORT_ALT_DEFINES_VH
`define PORT_WIDTH          8
`define OFS_OUTPUT_LATCH    12'h018
`define OFS_DIRECTION       12'h020
`define OFS_ALT_SELECT      12'h028
`define OFS_BUS_CONFIG      12'h030
`define RST_LATCH           8'h00
`define RST_CFG_STRAP_HIGH  8'h00
`define RST_CFG_STRAP_LOW   8'hFF
`define ALT_PRESENT         8'hFF
`define HTRANS_NONSEQ_BIT   1
`endif

/* File: hdl/port_pin_cell.v */
// Purpose: one pin's pad control and read-back mux
// Assumes: inputs synchronous to hclk, pad resolves pull-up externally
// Notes:   purely combinational
`timescale 1ns/1ps
module port_pin_cell (
	// Configuration
	input  wire dir,
	input  wire alt_sel,
	input  wire latch,
	// Alternate peripheral
	input  wire has_alt,
	input  wire alt_out,
	input  wire alt_oe,
	// Pad
	input  wire pin_in,
	output wire pad_out,
	output wire pad_oe,
	output wire pad_pullup,
	// Read-back
	output wire read_bit
);
	wire alt_value;

	assign alt_value  = has_alt ? alt_out : 1'b0;
	assign pad_pullup = ~dir & alt_sel;
	// Alt mode lets the bus unit turn the data line around for reads
	assign pad_oe     = dir & (~alt_sel | ~has_alt | alt_oe);
	assign pad_out    = (dir & alt_sel) ? alt_value : latch;
	assign read_bit   = ~dir ? pin_in
	                  : (alt_sel ? alt_value : latch);
endmodule

/* File: hdl/port_alt_function_select.v */
// Purpose: port 0 direction, latch and alternate-function selection
// Assumes: single AHB-Lite master, word transfers, zero wait states
// Notes:   reset covers every system reset source via hresetn
// Notes:   a read directly behind a write sees the new settings
// Notes:   pins without an alternate function are masked in the header
`timescale 1ns/1ps
`include "port_alt_defines.vh"
module port_alt_function_select (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [11:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Strap
	input  wire        external_access_strap,
	// External memory bus unit
	input  wire [7:0]  bus_data_out,
	input  wire [7:0]  bus_addr_out,
	input  wire        bus_addr_phase,
	input  wire        bus_data_oe,
	output wire [7:0]  bus_data_in,
	// Pads
	input  wire [7:0]  pin_in,
	output wire [7:0]  pad_out,
	output wire [7:0]  pad_oe,
	output wire [7:0]  pad_pullup
);
	// Register state
	reg  [7:0]  port0_output_latch;
	reg  [7:0]  port0_direction;
	reg  [7:0]  port0_alt_select;
	reg         multiplexed_bus;
	reg         strap_pending;
	reg         wr_pending;
	reg  [11:0] wr_addr;
	reg  [31:0] rdata;
	reg  [31:0] next_rdata;

	// Bus decode
	wire        access;
	wire        access_read;
	wire        access_write;
	wire        wr_enable;
	reg         wr_latch;
	reg         wr_dir;
	reg         wr_alt;
	reg         wr_cfg;

	// Settings as a read in this cycle sees them
	reg  [7:0]  eff_latch;
	reg  [7:0]  eff_dir;
	reg  [7:0]  eff_alt;
	reg         eff_mux;
	reg  [7:0]  eff_alt_out;

	// Pin side
	wire [7:0]  alt_present;
	wire [7:0]  read_bits;
	reg  [7:0]  alt_out;
	wire [7:0]  alt_oe;
	wire        addr_drive;
	wire        eff_addr_drive;

	// Zero wait states: every transfer completes in its first data phase
	assign access       = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
	assign access_read  = access & ~hwrite;
	assign access_write = access & hwrite;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign hrdata       = rdata;

	// Pins lacking an alternate function show 0 in alternate output
	assign alt_present = `ALT_PRESENT;

	// The strap capture edge owns the configuration registers, so a
	// write landing there is dropped rather than racing the strap
	assign wr_enable = wr_pending & ~strap_pending;
	always @* begin
		wr_latch = 1'b0;
		wr_dir   = 1'b0;
		wr_alt   = 1'b0;
		wr_cfg   = 1'b0;
		if (wr_enable) begin
			case (wr_addr)
				`OFS_OUTPUT_LATCH: begin
					wr_latch = 1'b1;
				end
				`OFS_DIRECTION: begin
					wr_dir = 1'b1;
				end
				`OFS_ALT_SELECT: begin
					wr_alt = 1'b1;
				end
				`OFS_BUS_CONFIG: begin
					wr_cfg = 1'b1;
				end
				default: begin
					wr_latch = 1'b0;
				end
			endcase
		end
	end

	// A read right behind a write sees the value being written, so
	// back-to-back software sequences never read stale settings
	always @* begin
		eff_latch = port0_output_latch;
		eff_dir   = port0_direction;
		eff_alt   = port0_alt_select;
		eff_mux   = multiplexed_bus;
		if (wr_latch) begin
			eff_latch = hwdata[7:0];
		end
		if (wr_dir) begin
			eff_dir = hwdata[7:0];
		end
		if (wr_alt) begin
			eff_alt = hwdata[7:0];
		end
		if (wr_cfg) begin
			eff_mux = hwdata[0];
		end
	end

	// Address phase drives bus_addr_out in multiplexed mode
	assign addr_drive     = multiplexed_bus & bus_addr_phase;
	assign eff_addr_drive = eff_mux & bus_addr_phase;
	assign alt_oe         = {8{addr_drive | bus_data_oe}};
	assign bus_data_in    = pin_in;

	always @* begin
		if (addr_drive) begin
			alt_out = bus_addr_out;
		end else begin
			alt_out = bus_data_out;
		end
		if (eff_addr_drive) begin
			eff_alt_out = bus_addr_out;
		end else begin
			eff_alt_out = bus_data_out;
		end
	end

	// Pad side: one cell per pin from the stored settings
	genvar i;
	generate
		for (i = 0; i < `PORT_WIDTH; i = i + 1) begin : g_pin
			port_pin_cell u_cell (
				.dir        (port0_direction[i]),
				.alt_sel    (port0_alt_select[i]),
				.latch      (port0_output_latch[i]),
				.has_alt    (alt_present[i]),
				.alt_out    (alt_out[i]),
				.alt_oe     (alt_oe[i]),
				.pin_in     (pin_in[i]),
				.pad_out    (pad_out[i]),
				.pad_oe     (pad_oe[i]),
				.pad_pullup (pad_pullup[i]),
				.read_bit   ()
			);
		end
	endgenerate

	// Read side: the same cell fed with the forwarded settings
	generate
		for (i = 0; i < `PORT_WIDTH; i = i + 1) begin : g_read
			port_pin_cell u_read (
				.dir        (eff_dir[i]),
				.alt_sel    (eff_alt[i]),
				.latch      (eff_latch[i]),
				.has_alt    (alt_present[i]),
				.alt_out    (eff_alt_out[i]),
				.alt_oe     (alt_oe[i]),
				.pin_in     (pin_in[i]),
				.pad_out    (),
				.pad_oe     (),
				.pad_pullup (),
				.read_bit   (read_bits[i])
			);
		end
	endgenerate

	// Read data for the address taken this cycle; upper bits read 0
	always @* begin
		next_rdata = 32'h00000000;
		case (haddr)
			`OFS_OUTPUT_LATCH: begin
				next_rdata[7:0] = read_bits;
			end
			`OFS_DIRECTION: begin
				next_rdata[7:0] = eff_dir;
			end
			`OFS_ALT_SELECT: begin
				next_rdata[7:0] = eff_alt;
			end
			`OFS_BUS_CONFIG: begin
				next_rdata[0] = eff_mux;
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// The strap is sampled at the first edge after reset is released;
	// software must not start a transfer before the second edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_pending <= 1'b1;
		end else begin
			strap_pending <= 1'b0;
		end
	end

	// Address phase capture; the write lands in the data phase.
	// hsize is ignored: each register holds at most bits 7:0 of its own word
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_addr    <= 12'h000;
		end else begin
			wr_pending <= access_write;
			if (access) begin
				wr_addr <= haddr;
			end
		end
	end

	// hrdata stands from the read's address edge until the next read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= 32'h00000000;
		end else if (access_read) begin
			rdata <= next_rdata;
		end
	end

	// The latch takes writes whatever the pin direction
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port0_output_latch <= `RST_LATCH;
		end else if (wr_latch) begin
			port0_output_latch <= hwdata[7:0];
		end
	end

	// A low strap hands the pins to the external bus unit
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port0_direction <= `RST_CFG_STRAP_HIGH;
		end else if (strap_pending & ~external_access_strap) begin
			port0_direction <= `RST_CFG_STRAP_LOW;
		end else if (wr_dir) begin
			port0_direction <= hwdata[7:0];
		end
	end

	// Every reset returns the pins to their primary function first
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port0_alt_select <= `RST_CFG_STRAP_HIGH;
		end else if (strap_pending & ~external_access_strap) begin
			port0_alt_select <= `RST_CFG_STRAP_LOW;
		end else if (wr_alt) begin
			port0_alt_select <= hwdata[7:0];
		end
	end

	// Bus type select; separate data and address buses after reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			multiplexed_bus <= 1'b0;
		end else if (wr_cfg) begin
			multiplexed_bus <= hwdata[0];
		end
	end
endmodule

/* File: tb/port_alt_monitor.sv */
// Purpose: pad checks. Assumes: bound to block. Notes: registers unseen
`timescale 1ns/1ps
module port_alt_monitor (input wire hclk, hresetn, hreadyout, hresp,
	input wire external_access_strap, bus_data_oe, input wire [31:0] hrdata,
	input wire [7:0] bus_data_out, bus_data_in, pin_in, pad_out, pad_oe,
	input wire [7:0] pad_pullup);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_zero_wait: assert property (hreadyout) else $error("wait state");
	a_okay_resp: assert property (!hresp) else $error("error response");
	a_alt_input: assert property (bus_data_in == pin_in)
		else $error("alternate input differs from pin");
	a_pullup_input: assert property ((pad_pullup & pad_oe) == 0)
		else $error("pull-up on a driven pin");
	a_reset_idle: assert property (disable iff (0) !hresetn |->
		pad_oe == 0 && pad_pullup == 0) else $error("pins active in reset");
	a_strap_high: assert property ($rose(hresetn) && external_access_strap
		|=> pad_oe == 0 && pad_pullup == 0) else $error("strap high config");
	a_strap_low: assert property ($rose(hresetn) && !external_access_strap
		|=> pad_out == bus_data_out && pad_oe == {8{bus_data_oe}})
		else $error("strap low config");
	a_upper_zero: assert property (hrdata[31:8] == 0) else $error("upper bits");
endmodule
bind port_alt_function_select port_alt_monitor mon (.*);

/* File: tb/port_pin_world.sv */
// Purpose: pin side. Assumes: pad beats driver. Notes: float shows ~drive, 1 under pull-up
`timescale 1ns/1ps
module port_pin_world (input wire [7:0] pad_out, pad_oe, pad_pullup,
	input wire [7:0] ext_drive, ext_en, output wire [7:0] pin_in);
	assign pin_in = pad_oe & pad_out | ~pad_oe & (ext_en & ext_drive | ~ext_en & (pad_pullup | ~ext_drive));
endmodule

/* File: tb/port_alt_function_select_tb.sv */
// Purpose: port 0 bench. Assumes: zero wait. Notes: pads read at negedge
`timescale 1ns/1ps
module port_alt_function_select_tb;
	logic hclk = 0, hresetn = 1, hsel = 1, hwrite = 0, bus_addr_phase = 0;
	logic external_access_strap = 1, bus_data_oe = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [11:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [7:0] bus_data_out = 0, bus_addr_out = 0, ext_drive = 0, ext_en = 0;
	wire [31:0] hrdata;
	wire [7:0] bus_data_in, pin_in, pad_out, pad_oe, pad_pullup;
	wire hreadyout, hresp, hready = hreadyout;
	int num_errors = 0, checks = 0, cyc = 0;
	always #2.5 hclk = ~hclk;
	port_alt_function_select dut (.*);
	port_pin_world world (.*);
	task automatic chk(string n, logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic x(logic w, logic [11:0] a, logic [31:0] d);
		htrans <= 2'h2; haddr <= a; hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask
	task automatic rc(string n, logic [11:0] a, logic [7:0] e);
		x(0, a, 0);
		chk(n, e, hrdata);
	endtask
	task automatic wr_rd(logic [11:0] a, logic [31:0] d, logic [7:0] e);
		htrans <= 2'h2; haddr <= a; hwrite <= 1;
		do @(posedge hclk); while (hready !== 1'b1);
		hwrite <= 0; hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		do @(posedge hclk); while (hready !== 1'b1);
		chk("forward", e, hrdata);
	endtask
	task automatic rst(logic s);
		hresetn <= 0; external_access_strap <= s;
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		repeat (2) @(posedge hclk);
	endtask
	task automatic t_primary;
		rst(1);
		rc("direction", 12'h020, 8'h00);
		x(1, 12'h040, 8'hFF);
		rc("unmapped", 12'h040, 8'h00);
		x(1, 12'h020, 8'hFF);
		rc("latch", 12'h018, 8'h00);
		x(1, 12'h020, 8'h00);
		x(1, 12'h018, 8'h3C);
		ext_en <= 8'hFF; ext_drive <= 8'h5A;
		rc("pin", 12'h018, 8'h5A);
		ext_en <= 8'h30; ext_drive <= 8'h10;
		x(1, 12'h020, 8'h0F);
		x(1, 12'h028, 8'hC0);
		rc("pull-up", 12'h018, 8'hDC);
		x(1, 12'h018, hrdata ^ 32'h1);
		bus_data_out <= 8'hA5; bus_data_oe <= 1;
		x(1, 12'h020, 8'hFF);
		rc("modify", 12'h018, 8'h9D);
		x(1, 12'h030, 8'h01);
		bus_addr_phase <= 1; bus_addr_out <= 8'h3C;
		@(negedge hclk);
		chk("pad out", 8'h1D, pad_out);
		chk("pad oe", 8'hFF, pad_oe);
		@(posedge hclk);
	endtask
	task automatic t_strap_low;
		rst(0);
		rc("direction", 12'h020, 8'hFF);
		rc("select", 12'h028, 8'hFF);
		rc("alt data", 12'h018, 8'hA5);
		wr_rd(12'h020, 8'h0F, 8'h0F);
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge hclk) if (++cyc == 2000) begin
		num_errors++;
		tally_and_finish;
	end
	initial begin
		t_primary;
		t_strap_low;
		tally_and_finish;
	end
endmodule
